// file: inc/adct_pkg.sv
/*
  adct_pkg: register map, field positions, reset values, timing counts and
  carrier types shared by the converter control block.
  Assumes a 32-bit APB register bus and one 50 MHz system clock.
*/
package adct_pkg;

  // ****************************************************************
  // register map (printed offsets are word indices)
  // ****************************************************************
  localparam logic [7:0]  IDX_CONTROL   = 8'h26;
  localparam logic [7:0]  IDX_CLOCK_SEL = 8'h27;
  localparam logic [7:0]  IDX_RES_LOW   = 8'h24;
  localparam logic [7:0]  IDX_RES_HIGH  = 8'h25;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'h28;
  localparam logic [7:0]  IDX_IRQ_EN    = 8'h29;
  localparam logic [7:0]  IDX_IRQ_CLR   = 8'h2A;
  localparam logic [11:0] ADDR_CONTROL   = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_CLOCK_SEL = {2'b00, IDX_CLOCK_SEL, 2'b00};
  localparam logic [11:0] ADDR_RES_LOW   = {2'b00, IDX_RES_LOW, 2'b00};
  localparam logic [11:0] ADDR_RES_HIGH  = {2'b00, IDX_RES_HIGH, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STAT  = {2'b00, IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] ADDR_IRQ_EN    = {2'b00, IDX_IRQ_EN, 2'b00};
  localparam logic [11:0] ADDR_IRQ_CLR   = {2'b00, IDX_IRQ_CLR, 2'b00};

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          CTL_CHAN_LSB   = 0;
  localparam int          CTL_PORT_LSB   = 3;
  localparam int          CTL_PEND_BIT   = 6;
  localparam int          CTL_START_BIT  = 7;
  localparam int          CSEL_TEST_BIT  = 7;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [1:0]  CLKSEL_RESET   = 2'b00;
  localparam int          IRQ_DONE_BIT   = 0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          SYS_CLK_HZ      = 50_000_000;
  localparam int          CONV_TAPS       = 80;
  localparam int          SAMPLE_TAPS     = 32;
  localparam logic [1:0]  CSEL_DIV2       = 2'b00;
  localparam logic [1:0]  CSEL_DIV8       = 2'b01;
  localparam logic [1:0]  CSEL_DIV32      = 2'b10;
  localparam logic [4:0]  DIV2_TOP        = 5'h01;
  localparam logic [4:0]  DIV8_TOP        = 5'h07;
  localparam logic [4:0]  DIV32_TOP       = 5'h1F;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED  = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONV   = 2'b11
  } adct_state_e;

  typedef struct packed {
    logic [2:0] chanSel;
    logic [2:0] portCfg;
  } adct_cfg_s;

endpackage : adct_pkg

// file: logic/adct_tap_gen.sv
/*
  adct_tap_gen: divides the system clock into converter clock ticks.
  Assumes the caller holds clrDiv while no conversion is running.
*/
`timescale 1ns/1ps
module adct_tap_gen (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // control
  input  wire logic       clrDiv,
  input  wire logic [1:0] clkSel,
  // tick out
  output logic            tapTick
);
  import adct_pkg::*;

  logic [4:0] divCnt_q;
  logic [4:0] divCnt_d;
  logic [4:0] divTop;
  logic       tapTick_d;

  // R14 divider select
  always_comb begin
    unique case (clkSel)
      CSEL_DIV2:  divTop = DIV2_TOP;
      CSEL_DIV8:  divTop = DIV8_TOP;
      CSEL_DIV32: divTop = DIV32_TOP;
      // undefined code: slowest clock is the safe guess
      default:    divTop = DIV32_TOP;
    endcase
    tapTick_d = 1'b0;
    if (clrDiv) begin
      divCnt_d = 5'h00;
    end else if (divCnt_q >= divTop) begin
      divCnt_d  = 5'h00;
      tapTick_d = 1'b1;
    end else begin
      divCnt_d = divCnt_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q <= 5'h00;
      tapTick  <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tapTick  <= tapTick_d;
    end
  end

endmodule : adct_tap_gen

// file: logic/adct_control.sv
/*
  adct_control: APB register file and sequencer for an 8-channel 12-bit
  successive approximation converter.
  Assumes the analog core returns its 12-bit code on convCode by the end of
  the conversion and that APB inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
// Overview of operation
// R1 - eight input channels, each conversion yields a 12-bit result
// R2 - result bytes are read only; writes leave them unchanged
// R3 - high byte holds result 11..4, low byte bits 7..4 hold result 3..0
// R4 - control bits 2..0 pick the analog channel 0 to 7
// R5 - port field k makes lines 0..k-1 analog; 7 means all; 0 none
// R6 - analog lines lose digital I/O and pull-up; converter powered on
// R7 - port field zero powers the converter down
// R8 - pending flag at control bit 6; zero means conversion done
// R9 - start rising edge resets converter and sets pending flag
// R10 - conversion starts on start falling edge after a rising edge
// R11 - hardware clears pending flag when conversion completes
// R12 - each completion sets the converter interrupt request
// R13 - software keeps start low until pending flag returns to zero
// R14 - clock select 00 div2, 01 div8, 10 div32, 11 undefined
// R15 - software leaves clock register bit 7 alone; other unused read zero
// R16 - software pulses start after port field change, except to zero
// R17 - port change without start may leave pending flag; start restores it
// R18 - conversion lasts 80 converter clocks, first 32 sampling
// R19 - result bytes update together at completion and hold until next
module adct_control (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // analog core
  input  wire logic [11:0]     convCode,
  output logic      [2:0]      chanSel,
  output logic                 convPowerOn,
  output logic                 convReset,
  output logic                 sampleOn,
  // port b
  output logic      [7:0]      portbAnalog,
  // interrupt
  output logic                 irq
);
  import adct_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  adct_cfg_s   cfg_q,     cfg_d;
  logic        start_q,   start_d;
  logic        pend_q,    pend_d;
  logic [1:0]  clkSel_q,  clkSel_d;
  logic        testBit_q, testBit_d;
  logic [11:0] result_q,  result_d;
  logic        stat_q,    stat_d;
  logic        irqEn_q,   irqEn_d;
  adct_state_e state_q,   state_d;
  logic [6:0]  tapCnt_q,  tapCnt_d;
  logic [31:0] prdata_d;
  logic        irq_d;
  logic [7:0]  analog_d;
  logic        tapTick;
  logic        wrEn;
  logic        rdEn;
  logic        hit;
  logic [7:0]  wByte;
  logic        startRise;
  logic        startFall;
  logic        convDone;

  assign wrEn  = psel && penable && pwrite;
  assign rdEn  = psel && penable && !pwrite;
  assign wByte = pwdata[7:0];

  // ****************************************************************
  // converter clock
  // ****************************************************************
  adct_tap_gen u_tap (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clrDiv  (state_q == ST_IDLE || state_q == ST_ARMED),
    .clkSel  (clkSel_q),
    .tapTick (tapTick)
  );

  // ****************************************************************
  // start edges and sequencer
  // ****************************************************************
  assign startRise = wrEn && (paddr == ADDR_CONTROL) && wByte[CTL_START_BIT] && !start_q;
  assign startFall = wrEn && (paddr == ADDR_CONTROL) && !wByte[CTL_START_BIT] && start_q;
  assign convDone  = (state_q == ST_CONV) && tapTick && (tapCnt_q == 7'(CONV_TAPS - 1));

  always_comb begin
    state_d  = state_q;
    tapCnt_d = tapCnt_q;
    // R9 rise resets converter
    if (startRise) begin
      state_d  = ST_ARMED;
      tapCnt_d = 7'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          tapCnt_d = 7'h00;
        end
        // R10 fall after rise triggers
        ST_ARMED: begin
          if (startFall) begin
            state_d = ST_SAMPLE;
          end
        end
        // R18 sampling phase length
        ST_SAMPLE: begin
          if (tapTick) begin
            tapCnt_d = tapCnt_q + 7'h01;
            if (tapCnt_q == 7'(SAMPLE_TAPS - 1)) begin
              state_d = ST_CONV;
            end
          end
        end
        // R18 total conversion length
        ST_CONV: begin
          if (tapTick) begin
            tapCnt_d = tapCnt_q + 7'h01;
            if (convDone) begin
              state_d = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  always_comb begin
    cfg_d     = cfg_q;
    start_d   = start_q;
    pend_d    = pend_q;
    clkSel_d  = clkSel_q;
    testBit_d = testBit_q;
    result_d  = result_q;
    stat_d    = stat_q;
    irqEn_d   = irqEn_q;
    if (wrEn && paddr == ADDR_CONTROL) begin
      // R4 channel field
      cfg_d.chanSel = wByte[CTL_CHAN_LSB +: 3];
      // R5 port field
      cfg_d.portCfg = wByte[CTL_PORT_LSB +: 3];
      start_d       = wByte[CTL_START_BIT];
    end
    if (wrEn && paddr == ADDR_CLOCK_SEL) begin
      clkSel_d  = wByte[1:0];
      // R15 test bit kept but inert
      testBit_d = wByte[CSEL_TEST_BIT];
    end
    if (wrEn && paddr == ADDR_IRQ_EN) begin
      irqEn_d = wByte[IRQ_DONE_BIT];
    end
    if (wrEn && paddr == ADDR_IRQ_CLR && wByte[IRQ_DONE_BIT]) begin
      stat_d = 1'b0;
    end
    // R11 self clearing on completion
    // R19 coherent result capture
    // R2 only the sequencer writes results
    if (convDone) begin
      pend_d   = 1'b0;
      result_d = convCode;
      // R12 completion sets request; set beats clear
      stat_d   = 1'b1;
    end
    // R9 rise forces pending high
    // R17 start pulse restores flag
    // placed last: a rise in the final tap restarts, so pending must win
    if (startRise) begin
      pend_d = 1'b1;
    end
  end

  // ****************************************************************
  // read mux and outputs
  // ****************************************************************
  always_comb begin
    hit      = 1'b1;
    prdata_d = 32'h0000_0000;
    unique case (paddr)
      // R8 pending flag at bit 6
      ADDR_CONTROL:   prdata_d[7:0] = {start_q, pend_q, cfg_q.portCfg, cfg_q.chanSel};
      // R15 unused bits read zero
      ADDR_CLOCK_SEL: prdata_d[7:0] = {testBit_q, 5'b0_0000, clkSel_q};
      // R3 result byte packing
      ADDR_RES_HIGH:  prdata_d[7:0] = result_q[11:4];
      ADDR_RES_LOW:   prdata_d[7:0] = {result_q[3:0], 4'h0};
      ADDR_IRQ_STAT:  prdata_d[0]   = stat_q;
      ADDR_IRQ_EN:    prdata_d[0]   = irqEn_q;
      ADDR_IRQ_CLR:   prdata_d      = 32'h0000_0000;
      default:        hit           = 1'b0;
    endcase
    irq_d = (stat_d && irqEn_d);
    // R5 analog line map
    for (int i = 0; i < 8; i++) begin
      analog_d[i] = (cfg_d.portCfg == 3'b111) || (i < int'(cfg_d.portCfg));
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q       <= '0;
      start_q     <= CONTROL_RESET[CTL_START_BIT];
      pend_q      <= CONTROL_RESET[CTL_PEND_BIT];
      clkSel_q    <= CLKSEL_RESET;
      testBit_q   <= 1'b0;
      result_q    <= 12'h000;
      stat_q      <= 1'b0;
      irqEn_q     <= 1'b0;
      state_q     <= ST_IDLE;
      tapCnt_q    <= 7'h00;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      irq         <= 1'b0;
      chanSel     <= 3'b000;
      convPowerOn <= 1'b0;
      convReset   <= 1'b0;
      sampleOn    <= 1'b0;
      portbAnalog <= 8'h00;
    end else begin
      cfg_q       <= cfg_d;
      start_q     <= start_d;
      pend_q      <= pend_d;
      clkSel_q    <= clkSel_d;
      testBit_q   <= testBit_d;
      result_q    <= result_d;
      stat_q      <= stat_d;
      irqEn_q     <= irqEn_d;
      state_q     <= state_d;
      tapCnt_q    <= tapCnt_d;
      // no wait state: pready and read data registered from the setup cycle, valid in the first access cycle
      prdata      <= (psel && !penable && !pwrite) ? prdata_d : prdata;
      pready      <= psel && !penable;
      pslverr     <= psel && !penable && !hit;
      irq         <= irq_d;
      // R1 R4 channel to core
      chanSel     <= cfg_d.chanSel;
      // R6 R7 power follows port field
      convPowerOn <= (cfg_d.portCfg != 3'b000);
      convReset   <= (state_d == ST_ARMED);
      sampleOn    <= (state_d == ST_SAMPLE);
      // R6 digital path disabled where set
      portbAnalog <= analog_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_startPulse;
    startRise ##[1:1000] startFall;
  endsequence

  a_rise_sets_pend: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
    startRise |=> pend_q)
    else $error("pending flag not set by start rise");
  a_done_clears_pend: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
    convDone && !startRise |=> !pend_q)
    else $error("pending flag not cleared at completion");
  a_done_sets_irq: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    convDone |=> stat_q)
    else $error("completion did not set request");
  a_result_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // R19
    !convDone |=> $stable(result_q))
    else $error("result changed outside completion");
  a_result_capture: assert property (@(posedge sys_clk) disable iff (!resetn) // R2
    convDone |=> result_q == $past(convCode))
    else $error("result not captured");
  a_fall_starts_conv: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
    s_startPulse |=> state_q == ST_SAMPLE)
    else $error("start fall did not begin conversion");
  a_power_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
    convPowerOn == (cfg_q.portCfg != 3'b000))
    else $error("converter powered with port field zero");
  a_all_analog: assert property (@(posedge sys_clk) disable iff (!resetn) // R5
    ##1 $past(cfg_d.portCfg) == 3'b111 |-> portbAnalog == 8'hFF)
    else $error("port field seven not all analog");
  a_sample_len: assert property (@(posedge sys_clk) disable iff (!resetn) // R18
    state_q == ST_SAMPLE ##1 state_q == ST_CONV |-> tapCnt_q == 7'(SAMPLE_TAPS))
    else $error("sampling phase length wrong");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    irq == (stat_q && irqEn_q))
    else $error("interrupt output mismatch");

endmodule : adct_control

// file: verif/test_adc_control_twelve_bit.sv
/*
  test_adc_control_twelve_bit: self-checking bench for adct_control, driving
  the APB slave, the analog core code and watching the port-b and irq outputs.
  Assumes the assertions live in the design files and a 50 MHz sys_clk.
*/
`timescale 1ns/1ps
module test_adc_control_twelve_bit;
  import adct_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        sys_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] convCode;
  logic [2:0]  chanSel;
  logic        convPowerOn;
  logic        convReset;
  logic        sampleOn;
  logic [7:0]  portbAnalog;
  logic        irq;
  int          errorCnt;
  int          totalChecks;
  logic [31:0] rd;
  logic        err;

  adct_control adct_control_i (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convCode(convCode), .chanSel(chanSel), .convPowerOn(convPowerOn), .convReset(convReset),
    .sampleOn(sampleOn), .portbAnalog(portbAnalog), .irq(irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // request held until pready is sampled high at a rising edge; data taken at that edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errorCnt++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] portMask(input int k);
    return (k == 7) ? 8'hFF : 8'((1 << k) - 1);
  endfunction : portMask

  task settle;
    repeat (2) @(negedge sys_clk);
  endtask : settle

  task conv(input logic [1:0] cs);
    int         div;
    int         cyc;
    int         samp;
    logic [2:0] ch;
    logic [2:0] pc;
    logic [11:0] code;
    div  = (cs == 2'b00) ? 2 : (cs == 2'b01) ? 8 : 32;
    ch   = 3'($urandom);
    pc   = 3'($urandom_range(7, 1));
    code = 12'($urandom);
    convCode <= code;
    apb(1'b1, ADDR_CLOCK_SEL, {30'h0, cs});
    apb(1'b1, ADDR_CONTROL, {24'h0, 2'b10, pc, ch});
    @(negedge sys_clk);
    chk(convReset, 1'b1);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, {24'h0, 2'b11, pc, ch});
    chk(chanSel, ch);
    repeat (2) @(negedge sys_clk);
    chk(sampleOn, 1'b0);
    apb(1'b1, ADDR_CONTROL, {24'h0, 2'b00, pc, ch});
    cyc  = 0;
    samp = 0;
    while (irq !== 1'b1 && cyc < 3000) begin
      @(negedge sys_clk);
      cyc++;
      if (sampleOn === 1'b1) samp++;
    end
    chk(samp >= 32 * div - 1 && samp <= 32 * div + 1, 1'b1);
    chk(cyc >= 80 * div - 2 && cyc <= 80 * div + 4, 1'b1);
    @(posedge sys_clk);
    convCode <= ~code;
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, {24'h0, 2'b00, pc, ch});
    apb(1'b1, ADDR_RES_HIGH, 32'h0000_00FF);
    apb(1'b1, ADDR_RES_LOW, 32'h0000_00FF);
    apb(1'b0, ADDR_RES_HIGH, 32'h0);
    chk(rd, {24'h0, code[11:4]});
    apb(1'b0, ADDR_RES_LOW, 32'h0);
    chk(rd, {24'h0, code[3:0], 4'h0});
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    // masking and clearing the sticky completion bit
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    settle();
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_CLR, 32'h1);
    settle();
    chk(irq, 1'b0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
  endtask : conv

  task conclude;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    // longest path is four conversions, two at div32, plus short ones; far below this
    #1_000_000;
    errorCnt++;
    conclude();
  end

  initial begin
    logic [2:0] ch;
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; convCode = 12'h0;
    errorCnt = 0;
    totalChecks = 0;
    void'($urandom(32'h7d4c));
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk(portbAnalog, 8'h00);
    chk(irq, 1'b0);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_CLOCK_SEL, 32'h0);
    chk(rd, 32'h0);
    // bit 7 left clear: reserved for test
    apb(1'b1, ADDR_CLOCK_SEL, 32'h0000_007F);
    apb(1'b0, ADDR_CLOCK_SEL, 32'h0);
    chk(rd, 32'h0000_0003);
    // unmapped place: refused on both directions
    apb(1'b1, 12'hFFC, 32'h0000_00FF);
    chk(err, 1'b1);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // short conversions keep the port sweep cheap
    apb(1'b1, ADDR_CLOCK_SEL, {30'h0, CSEL_DIV2});
    for (int k = 0; k < 8; k++) begin
      ch = 3'($urandom);
      apb(1'b1, ADDR_CONTROL, {26'h0, 3'(k), ch});
      if (k != 0) begin
        apb(1'b1, ADDR_CONTROL, {24'h0, 2'b10, 3'(k), ch});
        apb(1'b1, ADDR_CONTROL, {26'h0, 3'(k), ch});
      end
      repeat (200) @(negedge sys_clk);
      chk(portbAnalog, portMask(k));
      chk(convPowerOn, k != 0);
      chk(chanSel, ch);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      chk(rd, {26'h0, 3'(k), ch});
    end
    // sweep conversions left the sticky bit set
    apb(1'b1, ADDR_IRQ_CLR, 32'h1);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    // code 11 included: runs at the slowest divider
    for (int c = 0; c < 4; c++) begin
      conv(2'(c));
    end
    conclude();
  end

endmodule : test_adc_control_twelve_bit
